// ==== rtl/command_ring_host_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module command_ring_host_port (
  input  wire logic                               mclk,
  input  wire logic                               resetn,
  input  wire logic [host_port_pkg::ADDR_W-1:0]   host_addr,
  input  wire logic [host_port_pkg::DATA_W-1:0]   host_wdata,
  input  wire logic                               host_write_n,
  input  wire logic                               host_read_n,
  output var  logic [host_port_pkg::DATA_W-1:0]   host_rdata,
  output var  logic                               host_ack,
  input  wire logic [host_port_pkg::COUNT_W-1:0]  ring_slot_count,
  output var  logic                               cmd_valid,
  input  wire logic                               cmd_ready,
  output var  logic                               cmd_from_master,
  output var  logic [host_port_pkg::DATA_W-1:0]   cmd_entry_control,
  output var  logic [host_port_pkg::DATA_W-1:0]   cmd_word1,
  output var  logic [host_port_pkg::DATA_W-1:0]   cmd_word2,
  output var  logic [host_port_pkg::DATA_W-1:0]   cmd_word3,
  output var  logic [host_port_pkg::DATA_W-1:0]   cmd_word4,
  output var  logic [host_port_pkg::DATA_W-1:0]   cmd_word5,
  output var  logic                               space_irq,
  output var  logic [host_port_pkg::LVL_W-1:0]    space_irq_level,
  output var  logic [host_port_pkg::VEC_W-1:0]    space_irq_vector,
  output var  logic                               thaw_valid,
  output var  logic                               thaw_error,
  output var  logic [host_port_pkg::QNUM_W-1:0]   thaw_queue
);
  import host_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic in_ring(input logic [ADDR_W-1:0] a);
    in_ring = (a >= ADDR_RING) && (a < ADDR_RING + ADDR_W'(RING_WORDS));
  endfunction
  function automatic logic [RING_IDX_W-1:0] ring_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - ADDR_RING;
    ring_index = d[RING_IDX_W-1:0];
  endfunction
  function automatic logic in_master(input logic [ADDR_W-1:0] a);
    in_master = (a >= ADDR_MASTER) && (a < ADDR_MASTER + ADDR_W'(SLOT_WORDS));
  endfunction
  function automatic logic [2:0] master_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - ADDR_MASTER;
    master_index = d[2:0];
  endfunction
  function automatic logic [RING_IDX_W-1:0] slot_base(input logic [SLOT_IDX_W-1:0] s);
    slot_base = RING_IDX_W'(s) * RING_IDX_W'(SLOT_WORDS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // host strobe synchronisers
  logic wr_level;
  logic rd_level;
  logic wr_prev;
  logic rd_prev;
  logic wr_go;
  logic rd_go;

  strobe_sync u_wr_sync (
    .mclk      (mclk),
    .resetn    (resetn),
    .async_in  (host_write_n),
    .level_out (wr_level)
  );
  strobe_sync u_rd_sync (
    .mclk      (mclk),
    .resetn    (resetn),
    .async_in  (host_read_n),
    .level_out (rd_level)
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_prev <= 1'b1;
      rd_prev <= 1'b1;
    end else begin
      wr_prev <= wr_level;
      rd_prev <= rd_level;
    end
  end

  assign wr_go = wr_prev & ~wr_level;
  assign rd_go = rd_prev & ~rd_level;

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [DATA_W-1:0]     ring_mem [0:RING_WORDS-1];
  logic [DATA_W-1:0]     master_mem [0:SLOT_WORDS-1];
  logic [DATA_W-1:0]     space_ctrl;
  logic [DATA_W-1:0]     ring_head_scratch;
  logic [DATA_W-1:0]     release_ctrl;
  logic [DATA_W-1:0]     response_status_word;
  logic                  clr_ring;
  logic                  clr_master;
  logic [SLOT_IDX_W-1:0] cur_slot;
  logic                  space_fire;
  logic                  release_take;

  // ring slots: host writes win over the device clearing ownership
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < RING_WORDS; i++) begin
        ring_mem[i] <= WORD_ZERO;
      end
    end else begin
      if (clr_ring) begin
        ring_mem[slot_base(cur_slot)][OWN_BIT] <= 1'b0;
      end
      if (wr_go && in_ring(host_addr)) begin
        ring_mem[ring_index(host_addr)] <= host_wdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < SLOT_WORDS; i++) begin
        master_mem[i] <= WORD_ZERO;
      end
    end else begin
      if (clr_master) begin
        master_mem[0][OWN_BIT] <= 1'b0;
      end
      if (wr_go && in_master(host_addr)) begin
        master_mem[master_index(host_addr)] <= host_wdata;
      end
    end
  end

  // head scratch is written only by the host, read only by the host
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ring_head_scratch <= WORD_ZERO;
    end else if (wr_go && host_addr == ADDR_HEAD) begin
      ring_head_scratch <= host_wdata;
    end
  end

  // space control: only the request bit is ever cleared by the device
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      space_ctrl <= WORD_ZERO;
    end else if (wr_go && host_addr == ADDR_SPACE_IRQ) begin
      space_ctrl <= host_wdata;
    end else if (space_fire) begin
      space_ctrl[REQ_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      release_ctrl <= WORD_ZERO;
    end else if (wr_go && host_addr == ADDR_RELEASE) begin
      release_ctrl <= host_wdata;
    end else if (release_take) begin
      release_ctrl[REL_BIT] <= 1'b0;
    end
  end

  // response status: device sets win over a host write
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      response_status_word <= WORD_ZERO;
    end else begin
      if (wr_go && host_addr == ADDR_RESP) begin
        response_status_word <= host_wdata;
      end
      if (space_fire) begin
        response_status_word[RESP_SPACE_BIT] <= 1'b1;
        response_status_word[RESP_VALID_BIT] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host read port
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      host_rdata <= WORD_ZERO;
      host_ack   <= 1'b0;
    end else begin
      host_ack <= wr_go | rd_go;
      if (rd_go) begin
        if (in_ring(host_addr)) begin
          host_rdata <= ring_mem[ring_index(host_addr)];
        end else if (in_master(host_addr)) begin
          host_rdata <= master_mem[master_index(host_addr)];
        end else if (host_addr == ADDR_SPACE_IRQ) begin
          host_rdata <= space_ctrl;
        end else if (host_addr == ADDR_HEAD) begin
          host_rdata <= ring_head_scratch;
        end else if (host_addr == ADDR_RELEASE) begin
          host_rdata <= release_ctrl;
        end else if (host_addr == ADDR_RESP) begin
          host_rdata <= response_status_word;
        end else begin
          host_rdata <= WORD_ZERO;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ring engine
  engine_state_t        eng_state;
  logic [COUNT_W-1:0]   slot_count;
  logic                 master_busy;
  logic                 ring_busy;
  // a count of zero is treated as one slot
  assign slot_count  = (ring_slot_count == '0) ? COUNT_W'(1) : ring_slot_count;
  assign master_busy = master_mem[0][OWN_BIT];
  assign ring_busy   = ring_mem[slot_base(cur_slot)][OWN_BIT];
  assign clr_master  = (eng_state == ENG_OFFER) && cmd_ready && cmd_from_master;
  assign clr_ring    = (eng_state == ENG_OFFER) && cmd_ready && !cmd_from_master;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      eng_state <= ENG_SCAN;
      cur_slot  <= '0;
      cmd_valid <= 1'b0;
    end else begin
      unique case (eng_state)
        ENG_SCAN: begin
          if (master_busy || ring_busy) begin
            eng_state <= ENG_OFFER;
            cmd_valid <= 1'b1;
          end
        end
        ENG_OFFER: begin
          if (cmd_ready) begin
            eng_state <= ENG_SCAN;
            cmd_valid <= 1'b0;
            if (!cmd_from_master) begin
              if (COUNT_W'(cur_slot) + COUNT_W'(1) >= slot_count) begin
                cur_slot <= '0;
              end else begin
                cur_slot <= cur_slot + SLOT_IDX_W'(1);
              end
            end
          end
        end
      endcase
    end
  end

  // copy the slot when it is offered; master slot has priority
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cmd_from_master   <= 1'b0;
      cmd_entry_control <= WORD_ZERO;
      cmd_word1         <= WORD_ZERO;
      cmd_word2         <= WORD_ZERO;
      cmd_word3         <= WORD_ZERO;
      cmd_word4         <= WORD_ZERO;
      cmd_word5         <= WORD_ZERO;
    end else if (eng_state == ENG_SCAN) begin
      if (master_busy) begin
        cmd_from_master   <= 1'b1;
        cmd_entry_control <= master_mem[0];
        cmd_word1         <= master_mem[1];
        cmd_word2         <= master_mem[2];
        cmd_word3         <= master_mem[3];
        cmd_word4         <= master_mem[4];
        cmd_word5         <= master_mem[5];
      end else if (ring_busy) begin
        cmd_from_master   <= 1'b0;
        cmd_entry_control <= ring_mem[slot_base(cur_slot)];
        cmd_word1         <= ring_mem[slot_base(cur_slot) + RING_IDX_W'(1)];
        cmd_word2         <= ring_mem[slot_base(cur_slot) + RING_IDX_W'(2)];
        cmd_word3         <= ring_mem[slot_base(cur_slot) + RING_IDX_W'(3)];
        cmd_word4         <= ring_mem[slot_base(cur_slot) + RING_IDX_W'(4)];
        cmd_word5         <= ring_mem[slot_base(cur_slot) + RING_IDX_W'(5)];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // space-available interrupt
  logic [COUNT_W-1:0] free_count;
  logic               space_met;
  logic               irq_armed;
  always_comb begin
    free_count = '0;
    for (int i = 0; i < MAX_SLOTS; i++) begin
      if ((COUNT_W'(i) < slot_count) && !ring_mem[i * SLOT_WORDS][OWN_BIT]) begin
        free_count = free_count + COUNT_W'(1);
      end
    end
  end

  always_comb begin
    if (space_ctrl[HALF_BIT]) begin
      space_met = free_count >= (slot_count >> 1);
    end else begin
      space_met = free_count != '0;
    end
  end

  // a host write in the same cycle defers the event to the next
  assign space_fire = space_ctrl[REQ_BIT] && space_met &&
                      !(wr_go && host_addr == ADDR_SPACE_IRQ);

  // request cleared at the fire edge, interrupt one edge later
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_armed        <= 1'b0;
      space_irq        <= 1'b0;
      space_irq_level  <= '0;
      space_irq_vector <= '0;
    end else begin
      irq_armed <= space_fire;
      space_irq <= irq_armed && (space_ctrl[LVL_LSB +: LVL_W] != '0);
      if (irq_armed) begin
        space_irq_level  <= space_ctrl[LVL_LSB +: LVL_W];
        space_irq_vector <= space_ctrl[VEC_LSB +: VEC_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // work queue release
  logic [QNUM_W-1:0] release_q;
  assign release_q    = WIDE_VARIANT ? release_ctrl[QNUM_LSB +: QNUM_W]
                                     : (release_ctrl[QNUM_LSB +: QNUM_W] & NARROW_MASK);
  assign release_take = release_ctrl[REL_BIT] && !(wr_go && host_addr == ADDR_RELEASE);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      thaw_valid <= 1'b0;
      thaw_error <= 1'b0;
      thaw_queue <= '0;
    end else begin
      thaw_valid <= release_take && (release_q != '0) &&
                    (WIDE_VARIANT || release_q <= NARROW_MAX_Q);
      thaw_error <= release_take && ((release_q == '0) ||
                    (!WIDE_VARIANT && release_q > NARROW_MAX_Q));
      if (release_take) begin
        thaw_queue <= release_q;
      end
    end
  end
endmodule // command_ring_host_port
`default_nettype wire

// ==== rtl/host_port_pkg.sv ====
`default_nettype none
package host_port_pkg;
  localparam int ADDR_W      = 10;
  localparam int DATA_W      = 16;
  localparam int SLOT_WORDS  = 6;
  localparam int MAX_SLOTS   = 16;
  localparam int RING_WORDS  = MAX_SLOTS * SLOT_WORDS;
  localparam int RING_IDX_W  = 7;
  localparam int SLOT_IDX_W  = 4;
  localparam int COUNT_W     = 5;
  localparam int QNUM_W      = 8;
  localparam int VEC_W       = 8;
  localparam int LVL_W       = 3;
  localparam int SYNC_STAGES = 3;

  // word addresses in the shared window
  localparam logic [ADDR_W-1:0] ADDR_SPACE_IRQ = 10'h002;
  localparam logic [ADDR_W-1:0] ADDR_HEAD      = 10'h003;
  localparam logic [ADDR_W-1:0] ADDR_RELEASE   = 10'h004;
  localparam logic [ADDR_W-1:0] ADDR_MASTER    = 10'h008;
  localparam logic [ADDR_W-1:0] ADDR_RING      = 10'h00e;
  localparam logic [ADDR_W-1:0] ADDR_RESP      = 10'h3a8;

  // field positions
  localparam int OWN_BIT        = 0;
  localparam int VEC_LSB        = 0;
  localparam int LVL_LSB        = 8;
  localparam int HALF_BIT       = 14;
  localparam int REQ_BIT        = 15;
  localparam int REL_BIT        = 0;
  localparam int QNUM_LSB       = 8;
  localparam int RESP_VALID_BIT = 0;
  localparam int RESP_SPACE_BIT = 4;

  localparam logic              WIDE_VARIANT = 1'b1;
  localparam logic [QNUM_W-1:0] NARROW_MAX_Q = 8'h0e;
  localparam logic [QNUM_W-1:0] NARROW_MASK  = 8'h0f;
  localparam logic [DATA_W-1:0] WORD_ZERO    = 16'h0000;

  typedef enum logic [0:0] {
    ENG_SCAN  = 1'b0,
    ENG_OFFER = 1'b1
  } engine_state_t;
endpackage
`default_nettype wire

// ==== rtl/strobe_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module strobe_sync (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic async_in,
  output var  logic level_out
);
  import host_port_pkg::*;

  logic [SYNC_STAGES-1:0] stage;

  // three-stage chain, reset high (strobes idle high)
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stage <= '1;
    end else begin
      stage <= {stage[SYNC_STAGES-2:0], async_in};
    end
  end

  // change accepted once stages two and three agree
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      level_out <= 1'b1;
    end else if (stage[1] == stage[2]) begin
      level_out <= stage[2];
    end
  end
endmodule // strobe_sync
`default_nettype wire

// ==== tb/command_ring_host_port_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module command_ring_host_port_bench;
  import host_port_pkg::*;
  logic        mclk;
  logic        resetn;
  logic [9:0]  host_addr;
  logic [15:0] host_wdata;
  logic        host_write_n;
  logic        host_read_n;
  logic [15:0] host_rdata;
  logic        host_ack;
  logic [4:0]  ring_slot_count;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_from_master;
  logic [15:0] cmd_entry_control;
  logic [15:0] cmd_word1;
  logic [15:0] cmd_word2;
  logic [15:0] cmd_word3;
  logic [15:0] cmd_word4;
  logic [15:0] cmd_word5;
  logic        space_irq;
  logic [2:0]  space_irq_level;
  logic [7:0]  space_irq_vector;
  logic        thaw_valid;
  logic        thaw_error;
  logic [7:0]  thaw_queue;
  logic [31:0] q_rd[$];
  logic [31:0] q_cmd[$];
  logic [31:0] q_irq[$];
  logic [31:0] q_thaw[$];
  logic [31:0] q_tag[$];
  logic [7:0]  qtab[5];
  logic [15:0] v;
  logic [7:0]  vec;
  integer      seed;
  int          fails;
  int          num_checks;
  int          i;
  ////////////////////////////////////////////////////////////////////////
  command_ring_host_port u_dut (
    .mclk(mclk), .resetn(resetn), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_write_n(host_write_n), .host_read_n(host_read_n), .host_rdata(host_rdata),
    .host_ack(host_ack), .ring_slot_count(ring_slot_count), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_from_master(cmd_from_master), .cmd_entry_control(cmd_entry_control),
    .cmd_word1(cmd_word1), .cmd_word2(cmd_word2), .cmd_word3(cmd_word3), .cmd_word4(cmd_word4),
    .cmd_word5(cmd_word5),
    .space_irq(space_irq), .space_irq_level(space_irq_level), .space_irq_vector(space_irq_vector),
    .thaw_valid(thaw_valid), .thaw_error(thaw_error), .thaw_queue(thaw_queue)
  );
  host_model u_host (
    .mclk(mclk), .host_ack(host_ack), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_write_n(host_write_n), .host_read_n(host_read_n)
  );
  always #50 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic take(ref logic [31:0] q[$], input logic [31:0] got);
    if (q.size() == 0) cmp(got, ~got);
    else cmp(got, q.pop_front());
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    bit ok;
    u_host.access(1'b1, a, d, ok);
    if (!ok) begin
      fails++;
      summarize();
    end
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    bit ok;
    q_rd.push_back({16'h0000, e});
    u_host.access(1'b0, a, 16'h0000, ok);
    if (!ok) begin
      fails++;
      summarize();
    end
  endtask
  task automatic slot(input int n, input logic [15:0] w1);
    logic [9:0] b;
    b = (n < 0) ? ADDR_MASTER : ADDR_RING + 10'(6 * n);
    q_cmd.push_back({15'h0000, n < 0, w1});
    q_tag.push_back({w1, ~w1});
    wr(b + 10'h001, w1);
    wr(b + 10'h002, w1);  // host tag
    wr(b + 10'h003, ~w1);
    wr(b + 10'h004, 16'h0001);  // queue one, reserved zero
    wr(b, 16'h0001);  // ownership set last
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (resetn) begin
      if (host_ack === 1'b1 && host_read_n === 1'b0) take(q_rd, {16'h0000, host_rdata});
      if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
        take(q_cmd, {15'h0, cmd_from_master, cmd_word1});
        take(q_tag, {cmd_word2, cmd_word3});
        cmp({cmd_entry_control, cmd_word4}, 32'h00010001);
        cmp({16'h0000, cmd_word5}, 32'h00000000);
      end
      if (space_irq !== 1'b0) take(q_irq, {21'h0, space_irq_level, space_irq_vector});
      if (thaw_valid !== 1'b0 || thaw_error !== 1'b0) take(q_thaw, {22'h0, thaw_error, thaw_valid, thaw_queue});
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    cmd_ready = 1'b0;
    ring_slot_count = 5'd4;
    seed = 32'ha7737adc;
    fails = 0;
    num_checks = 0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    v = 16'($random(seed));
    wr(ADDR_HEAD, v);
    rd(ADDR_HEAD, v);
    rd(10'h3ff, 16'h0000);
    slot(0, 16'($random(seed)));
    slot(-1, 16'($random(seed)));
    for (i = 1; i < 4; i++) slot(i, 16'($random(seed)));
    rd(ADDR_RING, 16'h0001);
    vec = 8'($random(seed));
    q_irq.push_back({21'h0, 3'h3, vec});
    wr(ADDR_SPACE_IRQ, {2'b11, 3'b000, 3'h3, vec});  // set after full, reserved zero
    cmd_ready <= 1'b1;
    for (i = 0; i < 300 && q_cmd.size() + q_irq.size() > 0; i++) @(posedge mclk);
    if (q_cmd.size() + q_irq.size() > 0) fails++;
    rd(ADDR_SPACE_IRQ, {8'h43, vec});
    rd(ADDR_RESP, 16'h0011);
    rd(ADDR_RING + 10'h006, 16'h0000);
    cmd_ready <= 1'b0;
    for (i = 0; i < 4; i++) slot(i, 16'($random(seed)));
    q_irq.push_back({21'h0, 3'h1, 8'h07});
    wr(ADDR_SPACE_IRQ, 16'h8107);  // ring full again, one free slot enough
    cmd_ready <= 1'b1;
    for (i = 0; i < 300 && q_cmd.size() + q_irq.size() > 0; i++) @(posedge mclk);
    if (q_cmd.size() + q_irq.size() > 0) fails++;
    rd(ADDR_SPACE_IRQ, 16'h0107);
    wr(ADDR_SPACE_IRQ, 16'h0007);  // level zero only without request
    rd(ADDR_SPACE_IRQ, 16'h0007);
    qtab = '{8'h00, 8'h01, 8'h0e, 8'hff, 8'h00};
    qtab[4] = 8'($random(seed)) | 8'h01;
    for (i = 0; i < 5; i++) begin
      q_thaw.push_back({22'h0, qtab[i] == 8'h00, qtab[i] != 8'h00, qtab[i]});
      wr(ADDR_RELEASE, {qtab[i], 8'h01});
      rd(ADDR_RELEASE, {qtab[i], 8'h00});
    end
    repeat (5) @(posedge mclk);
    if (q_rd.size() + q_cmd.size() + q_irq.size() + q_thaw.size() + q_tag.size() > 0) fails++;
    summarize();
  end
endmodule // command_ring_host_port_bench
`default_nettype wire

// ==== tb/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        mclk,
  input  wire logic        host_ack,
  output var  logic [9:0]  host_addr,
  output var  logic [15:0] host_wdata,
  output var  logic        host_write_n,
  output var  logic        host_read_n
);
  initial begin
    host_addr = 10'h000;
    host_wdata = 16'hffff;
    host_write_n = 1'b1;
    host_read_n = 1'b1;
  end
  // one word; strobe held until ack is sampled
  task automatic access(input logic wr, input logic [9:0] a, input logic [15:0] d, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge mclk);
    host_addr <= a;
    host_wdata <= d;
    if (wr) host_write_n <= 1'b0;
    else host_read_n <= 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge mclk);
      ok = (host_ack === 1'b1);
    end
    host_write_n <= 1'b1;
    host_read_n <= 1'b1;
    host_wdata <= ~d;
    repeat (6) @(posedge mclk);
  endtask
endmodule // host_model
`default_nettype wire

// ==== tb/ring_port_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module ring_port_asserts (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [15:0] cmd_entry_control,
  input wire logic [15:0] cmd_word1,
  input wire logic        space_irq,
  input wire logic [2:0]  space_irq_level,
  input wire logic [7:0]  space_irq_vector,
  input wire logic        thaw_valid,
  input wire logic        thaw_error,
  input wire logic [7:0]  thaw_queue
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  sequence s_offer;
    cmd_valid && !cmd_ready;
  endsequence
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_irq;
    space_irq ##1 !space_irq;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  property p_cmd_hold;
    s_offer |=> cmd_valid && $stable(cmd_word1) && $stable(cmd_entry_control);
  endproperty
  property p_cmd_free;
    s_take |=> !cmd_valid;
  endproperty
  property p_cmd_own;
    cmd_valid |-> cmd_entry_control[0];
  endproperty
  property p_irq_once;
    space_irq |-> s_irq;
  endproperty
  property p_irq_level;
    space_irq |-> space_irq_level != 3'h0;
  endproperty
  property p_irq_hold;
    space_irq |=> $stable(space_irq_vector) && $stable(space_irq_level);
  endproperty
  property p_thaw_ok;
    thaw_valid |-> !thaw_error && thaw_queue != 8'h00;
  endproperty
  property p_thaw_bad;
    thaw_error |-> thaw_queue == 8'h00;
  endproperty
  property p_thaw_q;
    $changed(thaw_queue) |-> thaw_valid || thaw_error;
  endproperty
  ////////////////////////////////////////////////////////////////////////
  a_cmd_hold: assert property (p_cmd_hold) else $error("offer changed before accept");
  a_cmd_free: assert property (p_cmd_free) else $error("offer not dropped");
  a_cmd_own: assert property (p_cmd_own) else $error("offer without ownership");
  a_irq_once: assert property (p_irq_once) else $error("space irq too long");
  a_irq_level: assert property (p_irq_level) else $error("space irq at level zero");
  a_irq_hold: assert property (p_irq_hold) else $error("irq vector changed");
  a_thaw_ok: assert property (p_thaw_ok) else $error("bad thaw");
  a_thaw_bad: assert property (p_thaw_bad) else $error("bad thaw error");
  a_thaw_q: assert property (p_thaw_q) else $error("queue moved alone");
endmodule // ring_port_asserts
bind command_ring_host_port ring_port_asserts u_chk (
  .mclk(mclk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_entry_control(cmd_entry_control), .cmd_word1(cmd_word1), .space_irq(space_irq),
  .space_irq_level(space_irq_level), .space_irq_vector(space_irq_vector),
  .thaw_valid(thaw_valid), .thaw_error(thaw_error), .thaw_queue(thaw_queue)
);
`default_nettype wire
